// File: rtl/codec_flags_filter_detect_regs.sv
`timescale 1ns/1ps
`include "codec_regs_defs.svh"

module codec_flags_filter_detect_regs #(
  parameter int unsigned TICK_CYC = `BASE_TICK_CYC
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Control port.
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic [7:0]      regRdata,
  // Overflow events: left ADC, right ADC, left DAC, right DAC.
  input  wire logic [3:0] ovfEvent,
  // Raw detection inputs.
  input  wire logic       stereoJackRaw,
  input  wire logic       cellJackRaw,
  input  wire logic       buttonRaw,
  // Controls to the datapaths.
  output logic [4:0]      pllDivider,
  output logic [1:0]      hpfLeftSel,
  output logic [1:0]      hpfRightSel,
  output logic            fxLeftEn,
  output logic            deemphLeftEn,
  output logic            fxRightEn,
  output logic            deemphRightEn,
  output logic            detectEn,
  output logic            buttonFlag
);
  logic [3:0] ovf_reg;
  logic [3:0] ovf_next;
  logic [3:0] pllDiv_reg;
  logic [3:0] pllDiv_next;
  logic [7:0] filter_reg;
  logic [7:0] filter_next;
  logic       detEn_reg;
  logic       detEn_next;
  logic [2:0] jackDb_reg;
  logic [2:0] jackDb_next;
  logic [1:0] btnDb_reg;
  logic [1:0] btnDb_next;
  logic       btnFlag_reg;
  logic       btnFlag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       btnPrev_reg;
  logic       btnPrev_next;

  logic [16:0] baseCnt_reg;
  logic [16:0] baseCnt_next;
  logic [5:0]  tickDiv_reg;
  logic [5:0]  tickDiv_next;
  logic        baseTick;
  logic        jackTick;
  logic        btnTick;
  logic        stereoDb;
  logic        cellDb;
  logic        btnDb;
  logic        btnRise;
  codec_regs_pkg::accessory_t accType;

  // Divider field decode: code zero stands for sixteen.
  function automatic logic [4:0] pll_ratio(input logic [3:0] code);
    pll_ratio = (code == 4'h0) ? 5'h10 : {1'b0, code};
  endfunction

  // Tick of 2^n base periods: fires when the low n divider bits are all set.
  function automatic logic pow2_tick(input logic [5:0] div,
                                     input logic [2:0] n);
    logic [5:0] mask;
    mask = 6'((7'h01 << n) - 7'h01);
    pow2_tick = ((div & mask) == mask);
  endfunction

  // Base 1 ms tick and the binary divider behind the slower ticks.
  always_comb begin
    baseTick     = (baseCnt_reg == 17'(TICK_CYC - 1));
    baseCnt_next = baseTick ? 17'h0_0000 : baseCnt_reg + 17'h0_0001;
    tickDiv_next = baseTick ? tickDiv_reg + 6'h01 : tickDiv_reg;
  end

  // Jack sampling tick is 2 ms doubled per code; button 1 ms doubled.
  assign jackTick = baseTick &&
                    pow2_tick(tickDiv_reg, 3'(jackDb_reg + 3'h1));
  assign btnTick  = baseTick &&
                    pow2_tick(tickDiv_reg, 3'(btnDb_reg - 2'h1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      baseCnt_reg <= 17'h0_0000;
      tickDiv_reg <= 6'h00;
    end else begin
      baseCnt_reg <= baseCnt_next;
      tickDiv_reg <= tickDiv_next;
    end
  end

  // Debouncers see the raw inputs only while detection is enabled, else a low level.
  debounce_unit stereoDebounce (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .tick      (jackTick),
    .bypass    (1'b0),
    .rawIn     (stereoJackRaw & detEn_reg),
    .stableOut (stereoDb)
  );
  debounce_unit cellDebounce (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .tick      (jackTick),
    .bypass    (1'b0),
    .rawIn     (cellJackRaw & detEn_reg),
    .stableOut (cellDb)
  );
  // Code 00 passes the button straight through.
  debounce_unit buttonDebounce (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .tick      (btnTick),
    .bypass    (btnDb_reg == 2'b00),
    .rawIn     (buttonRaw & detEn_reg),
    .stableOut (btnDb)
  );

  // Detected type follows the debounced jack levels.
  assign accType =
    codec_regs_pkg::accessory_t'({cellDb, stereoDb});
  assign btnRise = btnDb && !btnPrev_reg;

  // Register writes, read data capture and sticky flags.
  always_comb begin
    ovf_next     = ovf_reg;
    pllDiv_next  = pllDiv_reg;
    filter_next  = filter_reg;
    detEn_next   = detEn_reg;
    jackDb_next  = jackDb_reg;
    btnDb_next   = btnDb_reg;
    btnFlag_next = btnFlag_reg;
    rdata_next   = rdata_reg;
    btnPrev_next = btnDb;
    if (regRd) begin
      case (regAddr)
        `OFS_OVF_PLL: begin
          rdata_next  = {ovf_reg, pllDiv_reg};
          ovf_next    = 4'h0;
        end
        `OFS_FILTER:  rdata_next = filter_reg;
        `OFS_DETECT:  rdata_next = {detEn_reg, accType, jackDb_reg, btnDb_reg};
        `OFS_DETECT_B: begin
          rdata_next   = 8'(btnFlag_reg) << `BTN_FLAG_BIT;
          btnFlag_next = 1'b0;
        end
        default:      rdata_next = 8'h00;
      endcase
    end
    if (regWr) begin
      case (regAddr)
        `OFS_OVF_PLL: pllDiv_next = regWdata[`PLLDIV_HI:`PLLDIV_LO];
        `OFS_FILTER:  filter_next = regWdata;
        `OFS_DETECT: begin
          detEn_next  = regWdata[`DET_EN_BIT];
          // Reserved codes are software's to avoid; stored as written.
          jackDb_next = regWdata[`JACK_DB_HI:`JACK_DB_LO];
          btnDb_next  = regWdata[`BTN_DB_HI:`BTN_DB_LO];
        end
        default: ;
      endcase
    end
    // Setting after the clear lets a same-cycle event win.
    ovf_next = ovf_next | ovfEvent;
    if (btnRise) begin
      btnFlag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovf_reg     <= 4'h0;
      pllDiv_reg  <= `PLLDIV_RST;
      filter_reg  <= `FILTER_RST;
      detEn_reg   <= 1'b0;
      jackDb_reg  <= 3'h0;
      btnDb_reg   <= 2'h0;
      btnFlag_reg <= 1'b0;
      rdata_reg   <= 8'h00;
      btnPrev_reg <= 1'b0;
    end else begin
      ovf_reg     <= ovf_next;
      pllDiv_reg  <= pllDiv_next;
      filter_reg  <= filter_next;
      detEn_reg   <= detEn_next;
      jackDb_reg  <= jackDb_next;
      btnDb_reg   <= btnDb_next;
      btnFlag_reg <= btnFlag_next;
      rdata_reg   <= rdata_next;
      btnPrev_reg <= btnPrev_next;
    end
  end

  // Datapath controls straight from the registers.
  assign regRdata      = rdata_reg;
  assign pllDivider    = pll_ratio(pllDiv_reg);
  assign hpfLeftSel    = filter_reg[`HPL_HI:`HPL_LO];
  assign hpfRightSel   = filter_reg[`HPR_HI:`HPR_LO];
  assign fxLeftEn      = filter_reg[`FX_L_BIT];
  assign deemphLeftEn  = filter_reg[`DEEMPH_L_BIT];
  assign fxRightEn     = filter_reg[`FX_R_BIT];
  assign deemphRightEn = filter_reg[`DEEMPH_R_BIT];
  assign detectEn      = detEn_reg;
  assign buttonFlag    = btnFlag_reg;

  // Overflow flags: set by events, held until read, never lost to a clear.
  ovf_sticky_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ovfEvent[0] && !(regRd && regAddr == `OFS_OVF_PLL)) ##1 1'b1
      |-> ovf_reg[0])
    else $error("Overflow flag did not latch.");
  ovf_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(regRd && regAddr == `OFS_OVF_PLL)
      |=> (ovf_reg & $past(ovf_reg)) == $past(ovf_reg))
    else $error("Overflow flag dropped without a read.");
  ovf_read_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regRd && regAddr == `OFS_OVF_PLL && ovfEvent == 4'h0)
      |=> ovf_reg == 4'h0 && rdata_reg[7:4] == $past(ovf_reg))
    else $error("Overflow read did not return then clear.");
  ovf_same_cycle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regRd && regAddr == `OFS_OVF_PLL && ovfEvent[3]) |=> ovf_reg[3])
    else $error("Overflow lost to read clear.");

  // Reset values and the written control fields.
  reset_values_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !$past(rst_n) |-> ovf_reg == 4'h0 && pllDiv_reg == `PLLDIV_RST &&
      filter_reg == `FILTER_RST && !detEn_reg && !btnFlag_reg)
    else $error("Register left reset with a wrong value.");
  pll_decode_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pllDivider == ((pllDiv_reg == 4'h0) ? 5'h10 : {1'b0, pllDiv_reg}))
    else $error("PLL divider decode wrong.");
  filter_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regWr && regAddr == `OFS_FILTER)
      |=> {hpfLeftSel, hpfRightSel, fxLeftEn, deemphLeftEn,
           fxRightEn, deemphRightEn} == $past(regWdata))
    else $error("Filter controls did not follow write.");
  det_enable_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regWr && regAddr == `OFS_DETECT) |=> detectEn == $past(regWdata[7]))
    else $error("Detection enable did not follow write.");
  det_fields_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regWr && regAddr == `OFS_DETECT)
      |=> jackDb_reg == $past(regWdata[4:2]) &&
          btnDb_reg == $past(regWdata[1:0]))
    else $error("Debounce codes did not follow write.");

  // Button flag and the detected accessory type.
  btn_flag_set_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    btnRise |=> buttonFlag)
    else $error("Button flag did not latch.");
  btn_flag_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (regRd && regAddr == `OFS_DETECT_B && !btnRise) |=> !buttonFlag)
    else $error("Button flag not cleared by read.");
  btn_flag_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (buttonFlag && !(regRd && regAddr == `OFS_DETECT_B)) |=> buttonFlag)
    else $error("Button flag dropped without a read.");
  // Masked jacks cannot raise a type while detection is off.
  acc_type_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!detEn_reg && accType == codec_regs_pkg::ACC_NONE)
      |=> accType == codec_regs_pkg::ACC_NONE)
    else $error("Accessory type moved while detection was off.");
endmodule

// File: rtl/codec_regs_defs.svh
`ifndef CODEC_REGS_DEFS_SVH
`define CODEC_REGS_DEFS_SVH

// Register offsets on the control port.
`define OFS_OVF_PLL        8'h0b
`define OFS_FILTER         8'h0c
`define OFS_DETECT         8'h0d
`define OFS_DETECT_B       8'h0e

// Field positions.
`define OVF_HI             7
`define OVF_LO             4
`define PLLDIV_HI          3
`define PLLDIV_LO          0
`define HPL_HI             7
`define HPL_LO             6
`define HPR_HI             5
`define HPR_LO             4
`define FX_L_BIT           3
`define DEEMPH_L_BIT       2
`define FX_R_BIT           1
`define DEEMPH_R_BIT       0
`define DET_EN_BIT         7
`define DET_TYPE_HI        6
`define DET_TYPE_LO        5
`define JACK_DB_HI         4
`define JACK_DB_LO         2
`define BTN_DB_HI          1
`define BTN_DB_LO          0
`define BTN_FLAG_BIT       5

// Reset values.
`define PLLDIV_RST         4'h1
`define FILTER_RST         8'h00
`define DETECT_RST         8'h00

// Timing: the 1 ms base tick at the system clock rate.
`define CLK_NS             10
`define BASE_TICK_NS       1000000
`define BASE_TICK_CYC      (`BASE_TICK_NS / `CLK_NS)
// Debounce length in ticks: 8 samples of the chosen tick; button code 00 bypasses it.
`define DB_SAMPLES         8

`endif

// File: rtl/codec_regs_pkg.sv
package codec_regs_pkg;
  // Accessory type reported by detection.
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_STEREO,
    ACC_CELL,
    ACC_BOTH
  } accessory_t;
endpackage

// File: rtl/debounce_unit.sv
`timescale 1ns/1ps
`include "codec_regs_defs.svh"

// Accepts a new input level only after eight equal samples on tick, or at once with bypass.
module debounce_unit (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Sampling.
  input  wire logic tick,
  input  wire logic bypass,
  input  wire logic rawIn,
  // Result.
  output logic      stableOut
);
  logic [3:0] runCnt_reg;
  logic [3:0] runCnt_next;
  logic       stable_reg;
  logic       stable_next;

  // A sample back at the held level restarts the run, so without bypass glitches never pass.
  always_comb begin
    runCnt_next = runCnt_reg;
    stable_next = stable_reg;
    if (bypass) begin
      stable_next = rawIn;
      runCnt_next = 4'h0;
    end else if (tick) begin
      if (rawIn == stable_reg) begin
        runCnt_next = 4'h0;
      end else if (runCnt_reg == 4'(`DB_SAMPLES - 1)) begin
        stable_next = rawIn;
        runCnt_next = 4'h0;
      end else begin
        runCnt_next = runCnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      runCnt_reg <= 4'h0;
      stable_reg <= 1'b0;
    end else begin
      runCnt_reg <= runCnt_next;
      stable_reg <= stable_next;
    end
  end

  assign stableOut = stable_reg;

  // Without bypass the output only moves on a tick.
  change_on_tick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!$past(bypass) && $past(rst_n) && stable_reg != $past(stable_reg))
      |-> $past(tick))
    else $error("Debounced level changed without a tick.");
endmodule

// File: verif/codec_flags_filter_detect_regs_tb.sv
`timescale 1ns/1ps
`include "codec_regs_defs.svh"

module codec_flags_filter_detect_regs_tb;
  // A short base tick keeps every debounce interval to at most 2048 cycles.
  localparam int unsigned TICK = 4;

  logic       clk_sys;
  logic       rst_n;
  logic       regWr;
  logic       regRd;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic [3:0] ovfEvent;
  logic       stereoJackRaw;
  logic       cellJackRaw;
  logic       buttonRaw;
  logic [4:0] pllDivider;
  logic [1:0] hpfLeftSel;
  logic [1:0] hpfRightSel;
  logic       fxLeftEn;
  logic       deemphLeftEn;
  logic       fxRightEn;
  logic       deemphRightEn;
  logic       detectEn;
  logic       buttonFlag;
  logic       rdDly;
  logic [7:0] expQ[$];
  logic [7:0] d;
  logic [3:0] pll;
  int         error_cnt;
  int         check_count;

  codec_flags_filter_detect_regs #(.TICK_CYC(TICK)) u_dut (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .regWr         (regWr),
    .regRd         (regRd),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regRdata      (regRdata),
    .ovfEvent      (ovfEvent),
    .stereoJackRaw (stereoJackRaw),
    .cellJackRaw   (cellJackRaw),
    .buttonRaw     (buttonRaw),
    .pllDivider    (pllDivider),
    .hpfLeftSel    (hpfLeftSel),
    .hpfRightSel   (hpfRightSel),
    .fxLeftEn      (fxLeftEn),
    .deemphLeftEn  (deemphLeftEn),
    .fxRightEn     (fxRightEn),
    .deemphRightEn (deemphRightEn),
    .detectEn      (detectEn),
    .buttonFlag    (buttonFlag)
  );

  // Free-running 100 MHz clock.
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // One comparison; a mismatch is reported and counted at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Single-cycle write strobe; the next access waits one edge more.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // Read strobe, optionally with an overflow event in the same cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [3:0] ev = 4'h0);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    ovfEvent <= ev;
    expQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b0;
    ovfEvent <= 4'h0;
  endtask

  // Read data lands one cycle after the strobe; compare it mid-cycle.
  always @(posedge clk_sys) rdDly <= regRd;
  always @(negedge clk_sys) begin
    if (rdDly) begin
      if (expQ.size() == 0) begin
        check(regRdata, 8'hxx);
      end else begin
        check(regRdata, expQ.pop_front());
      end
    end
  end

  // Watchdog: the sequence needs a few thousand cycles at most.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {rst_n, regWr, regRd, stereoJackRaw, cellJackRaw, buttonRaw} = '0;
    {regAddr, regWdata, ovfEvent, rdDly} = '0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(32'hd981b590));
    cyc(8);
    rst_n <= 1'b1;
    check({3'h0, pllDivider}, 8'h01);
    check({hpfLeftSel, hpfRightSel, fxLeftEn, deemphLeftEn, fxRightEn,
           deemphRightEn}, `FILTER_RST);
    rd(`OFS_OVF_PLL, 8'h01);
    rd(`OFS_FILTER, 8'h00);
    rd(`OFS_DETECT, 8'h00);
    // Every divider code; the flag field ignores the random upper bits.
    for (int i = 0; i < 16; i++) begin
      pll = 4'(i);
      wr(`OFS_OVF_PLL, {4'($urandom), pll});
      cyc(1);
      check({3'h0, pllDivider}, (i == 0) ? 8'h10 : 8'(i));
      rd(`OFS_OVF_PLL, {4'h0, pll});
    end
    // All highpass codes on both channels with random effect bits.
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), ~2'(i), 4'($urandom)};
      wr(`OFS_FILTER, d);
      cyc(1);
      check({hpfLeftSel, hpfRightSel, fxLeftEn, deemphLeftEn, fxRightEn,
             deemphRightEn}, d);
      rd(`OFS_FILTER, d);
    end
    // Unmapped offset: write ignored, reads zero, neighbour untouched.
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    rd(`OFS_FILTER, d);
    // Each overflow flag alone: sticky, then cleared by the read.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      ovfEvent <= 4'h1 << i;
      @(posedge clk_sys);
      ovfEvent <= 4'h0;
      cyc(3);
      rd(`OFS_OVF_PLL, {4'h1 << i, pll});
      rd(`OFS_OVF_PLL, {4'h0, pll});
    end
    // An event coinciding with the clearing read survives it.
    rd(`OFS_OVF_PLL, {4'h0, pll}, 4'ha);
    rd(`OFS_OVF_PLL, {4'ha, pll});
    rd(`OFS_OVF_PLL, {4'h0, pll});
    wr(`OFS_OVF_PLL, {4'hf, pll});
    rd(`OFS_OVF_PLL, {4'h0, pll});
    // Detection: jack code 000, button code 01.
    wr(`OFS_DETECT, 8'h81);
    cyc(1);
    check({7'h0, detectEn}, 8'h01);
    stereoJackRaw <= 1'b1;
    cyc(200);
    rd(`OFS_DETECT, 8'ha1);
    cellJackRaw <= 1'b1;
    cyc(200);
    rd(`OFS_DETECT, 8'he1);
    stereoJackRaw <= 1'b0;
    cyc(20);
    stereoJackRaw <= 1'b1;
    cyc(200);
    rd(`OFS_DETECT, 8'he1);
    // A press shorter than the interval is filtered out.
    buttonRaw <= 1'b1;
    cyc(8);
    buttonRaw <= 1'b0;
    cyc(100);
    rd(`OFS_DETECT_B, 8'h00);
    buttonRaw <= 1'b1;
    cyc(100);
    buttonRaw <= 1'b0;
    cyc(100);
    check({7'h0, buttonFlag}, 8'h01);
    rd(`OFS_DETECT_B, 8'h20);
    rd(`OFS_DETECT_B, 8'h00);
    // Disabled detection masks the jacks; every legal code reads back.
    wr(`OFS_DETECT, 8'h01);
    cyc(200);
    check({7'h0, detectEn}, 8'h00);
    for (int j = 0; j < 6; j++) begin
      d = {3'h0, 3'(j), 2'(j)};
      wr(`OFS_DETECT, d);
      rd(`OFS_DETECT, d);
    end
    // Slowest jack code with both jacks in, button code 11: 4 ms ticks.
    wr(`OFS_DETECT, 8'h97);
    buttonRaw <= 1'b1;
    cyc(100);
    buttonRaw <= 1'b0;
    cyc(100);
    rd(`OFS_DETECT_B, 8'h00);
    buttonRaw <= 1'b1;
    cyc(200);
    buttonRaw <= 1'b0;
    cyc(200);
    rd(`OFS_DETECT_B, 8'h20);
    // Six 64 ms ticks are not yet enough, eight are.
    cyc(1000);
    rd(`OFS_DETECT, 8'h97);
    cyc(600);
    rd(`OFS_DETECT, 8'hf7);
    // Button code 00: a two-cycle press is taken at once.
    wr(`OFS_DETECT, 8'h80);
    buttonRaw <= 1'b1;
    cyc(2);
    buttonRaw <= 1'b0;
    cyc(2);
    check({7'h0, buttonFlag}, 8'h01);
    rd(`OFS_DETECT, 8'he0);
    // A reset in mid-run returns every register to its reset value.
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(`OFS_OVF_PLL, 8'h01);
    rd(`OFS_FILTER, `FILTER_RST);
    rd(`OFS_DETECT, `DETECT_RST);
    rd(`OFS_DETECT_B, 8'h00);
    cyc(4);
    end_sim();
  end
endmodule
